// file: core/fpi_defines.svh
`ifndef FPI_DEFINES_SVH
`define FPI_DEFINES_SVH

// Clock rate in kHz, so that a time in ms times this is a cycle count
`define FPI_CLK_KHZ        125000
// Half of the roughly 1 Hz blink period, in ms
`define FPI_BLINK_HALF_MS  500
// Button contact settle time, in ms
`define FPI_DEBOUNCE_MS    10
// Time power may stay up after the off request, in ms
`define FPI_PWR_FAULT_MS   1000

// Button positions in the press vector
`define FPI_BTN_PWR        0
`define FPI_BTN_ID         1
`define FPI_BTN_RST        2
`define FPI_BTN_NMI        3
`define FPI_BTN_COUNT      4

// Reset values
`define FPI_ID_RST         1'b0
`define FPI_SLEEP_MEM_RST  1'b0

`endif

// file: core/fpi_pkg.sv
package fpi_pkg;
	// System sleep state reported by the chipset
	typedef enum logic [2:0] {
		FPI_S0 = 3'h0,
		FPI_S1 = 3'h1,
		FPI_S2 = 3'h2,
		FPI_S3 = 3'h3,
		FPI_S4 = 3'h4,
		FPI_S5 = 3'h5
	} fpi_sstate_t;

	// Severity carried by a fault indication command
	typedef enum logic [1:0] {
		FPI_SEV_NONE    = 2'h0,
		FPI_SEV_NONCRIT = 2'h1,
		FPI_SEV_CRIT    = 2'h2
	} fpi_sev_t;

	// Power control fault watcher
	typedef enum logic [2:0] {
		FPI_PF_IDLE  = 3'b001,
		FPI_PF_WAIT  = 3'b010,
		FPI_PF_FAULT = 3'b100
	} fpi_pf_state_t;
endpackage

// file: core/fpi_btn_if.sv
`timescale 1ns/1ps
`default_nettype none
// Debounced button press pulses from the button bank to the panel logic
interface fpi_btn_if #(
	parameter int N = 4
);
	logic [N-1:0] press;
	modport src (output press);
	modport dst (input press);
endinterface
`default_nettype wire

// file: core/fpi_debounce.sv
`timescale 1ns/1ps
`default_nettype none
// Synchronises and debounces active-low buttons, one pulse per press
module fpi_debounce #(
	parameter int N   = 4,
	parameter int CYC = 1250000
) (
	input  wire logic         mclk,
	input  wire logic         srst,
	input  wire logic [N-1:0] btn_n,
	fpi_btn_if.src            btn
);
	localparam int CW = (CYC > 1) ? $clog2(CYC) : 1;

	generate
		if (N < 1 || CYC < 2) begin : g_bad
			$error("fpi_debounce: N and CYC out of range");
		end
	endgenerate

	logic [N-1:0] sync1;
	logic [N-1:0] sync2;
	logic [N-1:0] stable;
	logic [N-1:0] next_press;

	// Two-stage synchroniser on the raw contacts
	always_ff @(posedge mclk) begin
		if (srst) begin
			sync1 <= '1;
			sync2 <= '1;
		end else begin
			sync1 <= btn_n;
			sync2 <= sync1;
		end
	end

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_btn
			logic [CW-1:0] cnt;
			wire settled = (cnt == CW'(CYC - 1));
			wire differ  = (sync2[i] != stable[i]);
			// Level must hold a full settle time before it is taken
			always_ff @(posedge mclk) begin
				if (srst) begin
					cnt       <= '0;
					stable[i] <= 1'b1;
				end else if (!differ) begin
					cnt <= '0;
				end else if (settled) begin
					cnt       <= '0;
					stable[i] <= sync2[i];
				end else begin
					cnt <= cnt + 1'b1;
				end
			end
			// Falling edge of the settled level is one press
			assign next_press[i] = differ & settled & ~sync2[i];
		end
	endgenerate

	// Registered press pulses
	always_ff @(posedge mclk) begin
		if (srst)
			btn.press <= '0;
		else
			btn.press <= next_press;
	end

	a_press_single : assert property (@(posedge mclk) disable iff (srst)
		btn.press[0] |=> !btn.press[0])
		else $error("press pulse longer than one cycle");
endmodule // fpi_debounce
`default_nettype wire

// file: core/fpi_top.sv
// Operation
// - Power LED steady on in S0 or legacy power on
// - Power LED blinks in sleep states S1 to S3
// - Power LED dark in S4, S5 or legacy power off
// - All blinking uses about one second period, equal on and off
// - Status green steady normal, blinking degraded, all off in POST/stop
// - Status amber steady critical, blinking non-critical
// - Amber on or blinking forces green off
// - Disk LED follows disk activity, dark when idle
// - Disk LED dark in S4, S5 or S1
// - Identify LED blinks while identification active, else dark
// - Identify button toggles front and baseboard identify together
// - Power button requests power toggle, or sleep when enabled
// - Reset button requests full reboot
// - Diagnostic button requests halt and non-maskable interrupt
// - Sleep indication retained, restored at power-up until firmware clears
// - Critical threshold crossing flags critical
// - Power staying on after off request flags critical fault
// - Fault indication command severity shown on status LED
// - Non-critical threshold or chassis intrusion flags non-critical
// - Degraded on lost redundancy, disabled processor or mapped-out memory
// - Monitor on front connector routes video front, rear disabled
`timescale 1ns/1ps
`default_nettype none
`include "fpi_defines.svh"
module fpi_top #(
	parameter int BLINK_HALF_CYC = `FPI_BLINK_HALF_MS * `FPI_CLK_KHZ,
	parameter int DEBOUNCE_CYC   = `FPI_DEBOUNCE_MS * `FPI_CLK_KHZ,
	parameter int PWR_FAULT_CYC  = `FPI_PWR_FAULT_MS * `FPI_CLK_KHZ
) (
	input  wire logic                  mclk,
	input  wire logic                  srst,
	// Chipset power state
	input  wire logic                  acpi_mode,
	input  wire fpi_pkg::fpi_sstate_t  sleep_state,
	input  wire logic                  legacy_power_on,
	input  wire logic                  fw_sleep_clear,
	input  wire logic                  sleep_enable,
	// Health conditions from the management controller
	input  wire logic                  crit_threshold,
	input  wire logic                  noncrit_threshold,
	input  wire logic                  chassis_intrusion,
	input  wire logic                  psu_redundancy_lost,
	input  wire logic                  psu_redundant_cfg,
	input  wire logic                  cpu_disabled,
	input  wire logic                  mem_mapped_out,
	input  wire logic                  status_blank,
	input  wire logic                  bmc_power_on_req,
	input  wire logic                  sys_power_good,
	input  wire logic                  fault_cmd_valid,
	input  wire fpi_pkg::fpi_sev_t     fault_cmd_sev,
	input  wire logic                  id_cmd_valid,
	input  wire logic                  id_cmd_on,
	// Pins
	input  wire logic                  disk_act_n,
	input  wire logic                  front_monitor_present_n,
	input  wire logic [3:0]            btn_n,
	// LEDs
	output logic                       power_led,
	output logic                       status_green,
	output logic                       status_amber,
	output logic                       disk_led,
	output logic                       id_led,
	output logic                       bb_id_led,
	// Requests
	output logic                       power_toggle_req,
	output logic                       sleep_req,
	output logic                       reset_req,
	output logic                       nmi_req,
	output logic                       diag_halt_req,
	output logic                       power_fault,
	// Video routing
	output logic                       front_video_en,
	output logic                       rear_video_en
);
	import fpi_pkg::*;

	localparam int BW = $clog2(BLINK_HALF_CYC);
	localparam int FW = $clog2(PWR_FAULT_CYC);

	generate
		if (BLINK_HALF_CYC < 2 || PWR_FAULT_CYC < 2) begin : g_bad
			$error("fpi_top: timing counts out of range");
		end
	endgenerate

	fpi_btn_if #(.N(`FPI_BTN_COUNT)) btn ();

	// Button bank
	fpi_debounce #(
		.N   (`FPI_BTN_COUNT),
		.CYC (DEBOUNCE_CYC)
	) u_debounce (
		.mclk  (mclk),
		.srst  (srst),
		.btn_n (btn_n),
		.btn   (btn)
	);

	// Pin synchronisers for disk activity and front monitor sense
	logic disk_s1;
	logic disk_s2;
	logic mon_s1;
	logic mon_s2;
	always_ff @(posedge mclk) begin
		if (srst) begin
			disk_s1 <= 1'b1;
			disk_s2 <= 1'b1;
			mon_s1  <= 1'b1;
			mon_s2  <= 1'b1;
		end else begin
			disk_s1 <= disk_act_n;
			disk_s2 <= disk_s1;
			mon_s1  <= front_monitor_present_n;
			mon_s2  <= mon_s1;
		end
	end

	// Shared blink timebase
	logic [BW-1:0] blink_cnt;
	logic          blink_phase;
	wire blink_tick = (blink_cnt == BW'(BLINK_HALF_CYC - 1));
	always_ff @(posedge mclk) begin
		if (srst) begin
			blink_cnt   <= '0;
			blink_phase <= 1'b0;
		end else if (blink_tick) begin
			blink_cnt   <= '0;
			blink_phase <= ~blink_phase;
		end else begin
			blink_cnt <= blink_cnt + 1'b1;
		end
	end

	// Power state decode
	wire st_s0     = acpi_mode & (sleep_state == FPI_S0);
	wire st_s1     = acpi_mode & (sleep_state == FPI_S1);
	wire st_sleep  = acpi_mode & (sleep_state inside {FPI_S1, FPI_S2, FPI_S3});
	wire st_off    = acpi_mode & (sleep_state inside {FPI_S4, FPI_S5});
	wire pwr_dark  = st_off | (~acpi_mode & ~legacy_power_on);
	wire pwr_on    = st_s0 | (~acpi_mode & legacy_power_on);

	// Retained sleep indication; entry to sleep wins over a clear
	logic sleep_mem;
	always_ff @(posedge mclk) begin
		if (srst)
			sleep_mem <= `FPI_SLEEP_MEM_RST;
		else if (st_sleep)
			sleep_mem <= 1'b1;
		else if (fw_sleep_clear)
			sleep_mem <= 1'b0;
	end

	// Power LED selection
	wire pwr_blink      = st_sleep | sleep_mem;
	wire next_power_led = pwr_dark  ? 1'b0 :
	                      pwr_blink ? blink_phase :
	                      pwr_on;

	// Fault indication command severity, held until the next command
	fpi_sev_t cmd_sev;
	always_ff @(posedge mclk) begin
		if (srst)
			cmd_sev <= FPI_SEV_NONE;
		else if (fault_cmd_valid)
			cmd_sev <= fault_cmd_sev;
	end

	// Power control fault watcher
	fpi_pf_state_t pf_state;
	fpi_pf_state_t next_pf_state;
	logic [FW-1:0] pf_cnt;
	wire pf_stuck = ~bmc_power_on_req & sys_power_good;
	wire pf_done  = (pf_cnt == FW'(PWR_FAULT_CYC - 1));
	always_comb begin
		next_pf_state = pf_state;
		case (pf_state)
			FPI_PF_IDLE: begin
				if (pf_stuck)
					next_pf_state = FPI_PF_WAIT;
			end
			FPI_PF_WAIT: begin
				if (!pf_stuck)
					next_pf_state = FPI_PF_IDLE;
				else if (pf_done)
					next_pf_state = FPI_PF_FAULT;
			end
			FPI_PF_FAULT: begin
				if (!sys_power_good)
					next_pf_state = FPI_PF_IDLE;
			end
			default: next_pf_state = FPI_PF_IDLE;
		endcase
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			pf_state <= FPI_PF_IDLE;
			pf_cnt   <= '0;
		end else begin
			pf_state <= next_pf_state;
			pf_cnt   <= (pf_state == FPI_PF_WAIT) ? pf_cnt + 1'b1 : '0;
		end
	end
	wire next_power_fault = (next_pf_state == FPI_PF_FAULT);

	// Health classification
	wire cond_crit    = crit_threshold | power_fault |
	                    (cmd_sev == FPI_SEV_CRIT);
	wire cond_noncrit = noncrit_threshold | chassis_intrusion |
	                    (cmd_sev == FPI_SEV_NONCRIT);
	wire cond_degr    = (psu_redundancy_lost & psu_redundant_cfg) |
	                    cpu_disabled | mem_mapped_out;

	// Status LED selection, amber before green
	wire amber_act    = cond_crit | cond_noncrit;
	wire next_amber   = ~status_blank & (cond_crit ? 1'b1 :
	                    cond_noncrit & blink_phase);
	wire next_green   = ~status_blank & ~amber_act &
	                    (cond_degr ? blink_phase : 1'b1);

	// Disk LED
	wire disk_dark     = st_off | st_s1 | (~acpi_mode & ~legacy_power_on);
	wire next_disk_led = ~disk_s2 & ~disk_dark;

	// Identification state; a remote command overrides a same-cycle press
	logic id_active;
	always_ff @(posedge mclk) begin
		if (srst)
			id_active <= `FPI_ID_RST;
		else if (id_cmd_valid)
			id_active <= id_cmd_on;
		else if (btn.press[`FPI_BTN_ID])
			id_active <= ~id_active;
	end

	// Button requests
	wire pwr_press = btn.press[`FPI_BTN_PWR];
	wire nmi_press = btn.press[`FPI_BTN_NMI];

	// All outputs registered
	always_ff @(posedge mclk) begin
		if (srst) begin
			power_led        <= 1'b0;
			status_green     <= 1'b0;
			status_amber     <= 1'b0;
			disk_led         <= 1'b0;
			id_led           <= 1'b0;
			bb_id_led        <= 1'b0;
			power_toggle_req <= 1'b0;
			sleep_req        <= 1'b0;
			reset_req        <= 1'b0;
			nmi_req          <= 1'b0;
			diag_halt_req    <= 1'b0;
			power_fault      <= 1'b0;
			front_video_en   <= 1'b0;
			rear_video_en    <= 1'b1;
		end else begin
			power_led        <= next_power_led;
			status_green     <= next_green;
			status_amber     <= next_amber;
			disk_led         <= next_disk_led;
			id_led           <= id_active & blink_phase;
			bb_id_led        <= id_active;
			power_toggle_req <= pwr_press & ~sleep_enable;
			sleep_req        <= pwr_press & sleep_enable;
			reset_req        <= btn.press[`FPI_BTN_RST];
			nmi_req          <= nmi_press;
			diag_halt_req    <= nmi_press;
			power_fault      <= next_power_fault;
			front_video_en   <= ~mon_s2;
			rear_video_en    <= mon_s2;
		end
	end

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	sequence s_pf_hold_end;
		(pf_state == FPI_PF_WAIT) && pf_done && pf_stuck;
	endsequence
	sequence s_pf_flag;
		power_fault ##1 (status_amber || status_blank);
	endsequence

	a_amber_over_green : assert property (
		status_amber |-> !status_green)
		else $error("green lit with amber");
	a_power_off_dark : assert property (
		pwr_dark |=> !power_led)
		else $error("power LED lit while off");
	a_power_s0_on : assert property (
		st_s0 && !sleep_mem |=> power_led)
		else $error("power LED dark in S0");
	a_power_sleep_blink : assert property (
		st_sleep && !pwr_dark |=> power_led == $past(blink_phase))
		else $error("power LED not blinking in sleep");
	a_blink_half : assert property (
		!blink_tick |=> $stable(blink_phase))
		else $error("blink phase moved early");
	a_blink_toggle : assert property (
		blink_tick |=> blink_phase != $past(blink_phase))
		else $error("blink phase missed its toggle");
	a_disk_dark : assert property (
		disk_dark |=> !disk_led)
		else $error("disk LED lit while off or S1");
	a_id_toggle : assert property (
		btn.press[`FPI_BTN_ID] && !id_cmd_valid |=>
		id_active != $past(id_active) ##1 bb_id_led == $past(id_active))
		else $error("identify press did not toggle");
	a_power_sleep_req : assert property (
		pwr_press && sleep_enable |=> sleep_req && !power_toggle_req)
		else $error("sleep press not routed");
	a_nmi_halt : assert property (
		nmi_press |=> nmi_req && diag_halt_req)
		else $error("diagnostic press lost");
	a_crit_amber : assert property (
		crit_threshold && !status_blank |=> status_amber && !status_green)
		else $error("critical not shown amber");
	a_pf_critical : assert property (
		s_pf_hold_end |=> s_pf_flag)
		else $error("power fault not flagged critical");
	a_video_front : assert property (
		!mon_s2 |=> front_video_en && !rear_video_en)
		else $error("front monitor not selected");
	a_blank_dark : assert property (
		status_blank |=> !status_green && !status_amber)
		else $error("status lit during blank");
	a_disk_follow : assert property (
		!disk_s2 && !disk_dark |=> disk_led)
		else $error("disk LED missed activity");
	a_id_dark : assert property (
		!id_active |=> !id_led)
		else $error("identify LED lit while inactive");
	a_reset_req : assert property (
		btn.press[`FPI_BTN_RST] |=> reset_req)
		else $error("reset press lost");
	a_sleep_retained : assert property (
		sleep_mem && !pwr_dark |=> power_led == $past(blink_phase))
		else $error("retained sleep not blinking");
	a_cmd_crit : assert property (
		cmd_sev == FPI_SEV_CRIT && !status_blank |=> status_amber)
		else $error("critical command not shown");
	a_noncrit_blink : assert property (
		(noncrit_threshold || chassis_intrusion) && !cond_crit &&
		!status_blank |=> status_amber == $past(blink_phase))
		else $error("non-critical not blinking amber");
	a_degr_blink : assert property (
		cond_degr && !amber_act && !status_blank |=>
		status_green == $past(blink_phase))
		else $error("degraded not blinking green");
endmodule // fpi_top
`default_nettype wire

// file: tb/fpi_bmc_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the management controller power rail and the disk pin
module fpi_bmc_model (
	input  wire logic mclk,
	input  wire logic srst,
	input  wire logic pwr_req,
	input  wire logic rail_stuck,
	input  wire logic disk_busy,
	output logic      pwr_good,
	output logic      disk_act_n
);
	logic [1:0] dly;

	// Rail follows the request late; a stuck rail stays up when told off
	always_ff @(posedge mclk) begin
		if (srst) begin
			dly      <= 2'h0;
			pwr_good <= 1'b0;
		end else begin
			dly      <= {dly[0], pwr_req | (rail_stuck & pwr_good)};
			pwr_good <= dly[1];
		end
	end

	// Activity pin, active low, changes only after a clock edge
	always_ff @(posedge mclk) begin
		disk_act_n <= ~disk_busy;
	end
endmodule // fpi_bmc_model
`default_nettype wire

// file: tb/fpi_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the front panel logic
module fpi_top_tb;
	import fpi_pkg::*;
	logic        mclk, srst, acpi_mode, legacy_power_on, fw_sleep_clear;
	logic        sleep_enable, crit, noncrit, intru, lost, rcfg, cpu, mem;
	logic        status_blank, pwr_req, pwr_good, fcv, icv, icon;
	logic        disk_act_n, mon_n, stuck, busy;
	logic [3:0]  btn_n;
	fpi_sstate_t sst;
	fpi_sev_t    sev;
	logic        power_led, status_green, status_amber, disk_led, id_led;
	logic        bb_id_led, tog, slp, rst, nmi, halt, power_fault, fv, rv;
	wire  [5:0]  leds;
	wire  [4:0]  reqs;
	int          error_cnt, n_checks;
	int          cnt [5];

	assign leds = {bb_id_led, id_led, disk_led, status_amber, status_green,
		power_led};
	assign reqs = {tog, slp, rst, nmi, halt};

	fpi_top #(.BLINK_HALF_CYC(8), .DEBOUNCE_CYC(4), .PWR_FAULT_CYC(8)) fpi_top_i (
		.mclk(mclk), .srst(srst), .acpi_mode(acpi_mode), .sleep_state(sst),
		.legacy_power_on(legacy_power_on), .fw_sleep_clear(fw_sleep_clear),
		.sleep_enable(sleep_enable), .crit_threshold(crit),
		.noncrit_threshold(noncrit), .chassis_intrusion(intru),
		.psu_redundancy_lost(lost), .psu_redundant_cfg(rcfg),
		.cpu_disabled(cpu), .mem_mapped_out(mem), .status_blank(status_blank),
		.bmc_power_on_req(pwr_req), .sys_power_good(pwr_good),
		.fault_cmd_valid(fcv), .fault_cmd_sev(sev), .id_cmd_valid(icv),
		.id_cmd_on(icon), .disk_act_n(disk_act_n),
		.front_monitor_present_n(mon_n), .btn_n(btn_n), .power_led(power_led),
		.status_green(status_green), .status_amber(status_amber),
		.disk_led(disk_led), .id_led(id_led), .bb_id_led(bb_id_led),
		.power_toggle_req(tog), .sleep_req(slp), .reset_req(rst),
		.nmi_req(nmi), .diag_halt_req(halt), .power_fault(power_fault),
		.front_video_en(fv), .rear_video_en(rv));

	fpi_bmc_model fpi_bmc_model_i (.mclk(mclk), .srst(srst), .pwr_req(pwr_req),
		.rail_stuck(stuck), .disk_busy(busy), .pwr_good(pwr_good),
		.disk_act_n(disk_act_n));

	// Clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// Request pulse counters
	always @(posedge mclk) begin
		for (int k = 0; k < 5; k++) cnt[k] += reqs[k];
	end

	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Lit cycles of one LED over two blink half periods
	task automatic lvl(input int i, input int exp);
		int n;
		n = 0;
		wt(4);
		repeat (16) begin
			wt(1);
			n += leds[i];
		end
		chk(n, exp);
	endtask

	task automatic final_report;
		if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic t_video;
		@(posedge mclk) mon_n <= 1'b0;
		wt(5);
		chk({fv, rv}, 2'b10);
		@(posedge mclk) mon_n <= 1'b1;
		wt(5);
		chk({fv, rv}, 2'b01);
	endtask

	// Health table: {crit,noncrit,intru,lost,rcfg,cpu,mem}, then lit counts
	task automatic t_status;
		logic [6:0] h [9] = '{7'h00, 7'h0c, 7'h08, 7'h02, 7'h01, 7'h20, 7'h10,
			7'h40, 7'h61};
		int g [9] = '{16, 8, 16, 8, 8, 0, 0, 0, 0};
		int a [9] = '{0, 0, 0, 0, 0, 8, 8, 16, 16};
		for (int k = 0; k < 9; k++) begin
			@(posedge mclk) {crit, noncrit, intru, lost, rcfg, cpu, mem} <= h[k];
			lvl(1, g[k]);
			lvl(2, a[k]);
		end
		@(posedge mclk) status_blank <= 1'b1;
		lvl(1, 0);
		lvl(2, 0);
		@(posedge mclk) {status_blank, crit, noncrit, intru, rcfg, mem} <= '0;
	endtask

	task automatic t_fault_cmd;
		fpi_sev_t s [3] = '{FPI_SEV_CRIT, FPI_SEV_NONCRIT, FPI_SEV_NONE};
		int a [3] = '{16, 8, 0};
		for (int k = 0; k < 3; k++) begin
			@(posedge mclk) begin
				fcv <= 1'b1;
				sev <= s[k];
			end
			@(posedge mclk) fcv <= 1'b0;
			lvl(2, a[k]);
			lvl(1, 16 - 2 * a[k] + (a[k] == 16 ? 16 : 0));
		end
	endtask

	task automatic t_power_fault;
		@(posedge mclk) begin
			stuck   <= 1'b1;
			pwr_req <= 1'b0;
		end
		wt(5);
		chk(power_fault, 1'b0);
		wt(10);
		chk(power_fault, 1'b1);
		lvl(2, 16);
		@(posedge mclk) stuck <= 1'b0;
		wt(6);
		chk(power_fault, 1'b0);
		@(posedge mclk) pwr_req <= 1'b1;
		lvl(1, 16);
	endtask

	task automatic t_disk;
		fpi_sstate_t s [3] = '{FPI_S0, FPI_S4, FPI_S1};
		int e [3] = '{16, 0, 0};
		@(posedge mclk) busy <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			@(posedge mclk) sst <= s[k];
			lvl(3, e[k]);
		end
		@(posedge mclk) begin
			busy <= 1'b0;
			sst  <= FPI_S0;
		end
		lvl(3, 0);
	endtask

	// Bounce, press and release one button; returns counted pulses
	task automatic press(input int i, output logic [9:0] p);
		wt(1);
		for (int k = 0; k < 5; k++) cnt[k] = 0;
		@(posedge mclk) btn_n[i] <= 1'b0;
		@(posedge mclk) btn_n[i] <= 1'b1;
		@(posedge mclk) btn_n[i] <= 1'b0;
		wt(20);
		@(posedge mclk) btn_n[i] <= 1'b1;
		wt(20);
		for (int k = 0; k < 5; k++) p[2*k +: 2] = cnt[k][1:0];
	endtask

	task automatic t_buttons;
		logic [9:0] p;
		press(0, p);
		chk(p, 10'h100);
		@(posedge mclk) sleep_enable <= 1'b1;
		press(0, p);
		chk(p, 10'h040);
		@(posedge mclk) sleep_enable <= 1'b0;
		press(2, p);
		chk(p, 10'h010);
		press(3, p);
		chk(p, 10'h005);
		press(1, p);
		chk({p, bb_id_led}, 11'h001);
		lvl(4, 8);
		press(1, p);
		lvl(5, 0);
		lvl(4, 0);
		@(posedge mclk) {icv, icon} <= 2'b11;
		@(posedge mclk) icv <= 1'b0;
		lvl(5, 16);
		lvl(4, 8);
	endtask

	task automatic t_power_led;
		fpi_sstate_t s [7] = '{FPI_S0, FPI_S4, FPI_S5, FPI_S3, FPI_S2, FPI_S1,
			FPI_S0};
		int e [7] = '{16, 0, 0, 8, 8, 8, 8};
		@(posedge mclk) fw_sleep_clear <= 1'b1;
		@(posedge mclk) fw_sleep_clear <= 1'b0;
		for (int k = 0; k < 7; k++) begin
			@(posedge mclk) sst <= s[k];
			lvl(0, e[k]);
		end
		@(posedge mclk) fw_sleep_clear <= 1'b1;
		@(posedge mclk) fw_sleep_clear <= 1'b0;
		lvl(0, 16);
		@(posedge mclk) begin
			acpi_mode <= 1'b0;
			sst       <= FPI_S4;
		end
		lvl(0, 16);
		@(posedge mclk) legacy_power_on <= 1'b0;
		lvl(0, 0);
	endtask

	// Watchdog
	initial begin
		#(8 * 20000);
		error_cnt++;
		final_report();
	end

	// Main sequence
	initial begin
		{srst, acpi_mode, legacy_power_on, pwr_req} = 4'hf;
		{fw_sleep_clear, sleep_enable, crit, noncrit, intru, lost} = '0;
		{rcfg, cpu, mem, status_blank, fcv, icv, icon, stuck, busy} = '0;
		{mon_n, btn_n} = 5'h1f;
		sst = FPI_S0;
		sev = FPI_SEV_NONE;
		error_cnt = 0;
		n_checks = 0;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		wt(10);
		t_video();
		t_status();
		t_fault_cmd();
		t_power_fault();
		t_disk();
		t_buttons();
		t_power_led();
		final_report();
	end
endmodule // fpi_top_tb
`default_nettype wire
